//--- cie_evt_src.sv
// Behavioural model of the CAN protocol engine that feeds events to the block.
`timescale 1ns/1ps
module cie_evt_src
  import cie_pkg::*;
#(
  parameter int NUM_CH = 2,
  parameter int NUM_RXF = 8
) (
  input wire logic clock,
  output cie_gerr_ev_t gerr_ev,
  output logic [NUM_RXF-1:0] rxf_ev,
  output cie_ch_ev_t ch_ev [NUM_CH]
);
  // The engine idles with no pulse and all error levels low.
  initial begin
    gerr_ev = '0;
    rxf_ev = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      ch_ev[i] = '0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Each task shows its event for one cycle and returns at the sampling edge.
  task automatic gerr_pulse(input cie_gerr_ev_t v);
    @(posedge clock);
    gerr_ev <= v;
    @(posedge clock);
    gerr_ev <= '0;
  endtask
  task automatic rxf_pulse(input logic [NUM_RXF-1:0] v);
    @(posedge clock);
    rxf_ev <= v;
    @(posedge clock);
    rxf_ev <= '0;
  endtask
  // Error levels persist after the pulse, since they are states, not events.
  task automatic ch_pulse(input int c, input cie_ch_ev_t v);
    cie_ch_ev_t hold;
    hold = '0;
    hold.warn_lvl = v.warn_lvl;
    hold.passive_lvl = v.passive_lvl;
    hold.bus_off_lvl = v.bus_off_lvl;
    @(posedge clock);
    ch_ev[c] <= v;
    @(posedge clock);
    ch_ev[c] <= hold;
  endtask
endmodule

//--- cie_irq_enable.sv
// Interrupt enable, latch and request logic of a multi-channel CAN controller.
`timescale 1ns/1ps
`include "cie_regs.svh"
module cie_irq_enable
  import cie_pkg::*;
#(
  parameter int NUM_CH = 2,
  parameter int NUM_TXBUF = 16,
  parameter int NUM_MF = 3,
  parameter int NUM_RXF = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire cie_gerr_ev_t gerr_ev,
  input wire logic [NUM_RXF-1:0] rxf_ev,
  input wire cie_ch_ev_t ch_ev [NUM_CH],
  output logic gerr_irq,
  output logic [NUM_RXF-1:0] rxf_irq,
  output logic [NUM_CH-1:0] tx_irq,
  output logic [NUM_CH-1:0] tx_abort_irq,
  output logic [NUM_CH-1:0] tx_queue_irq,
  output logic [NUM_CH-1:0] tx_history_irq,
  output logic [NUM_CH-1:0] cerr_irq,
  output logic [NUM_CH-1:0] multi_fifo_rx_irq,
  output logic [NUM_CH-1:0] multi_fifo_tx_irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Parameter checks and field masks.

  // The check allows four of the six channel blocks of the address map, and the event struct caps the transmit buffer and multi-purpose FIFO counts.
  if (NUM_CH < 1 || NUM_CH > 4 || NUM_TXBUF < 1 || NUM_TXBUF > `CIE_TXB_MAX ||
      NUM_MF < 1 || NUM_MF > `CIE_MF_MAX || NUM_RXF < 1 || NUM_RXF > 8) begin : g_bad
    $error("cie_irq_enable: parameter out of range");
  end

  localparam logic [15:0] TXB_ONES = 16'((33'h1 << NUM_TXBUF) - 33'h1);
  localparam logic [7:0] MF_ONES = 8'((9'h1 << NUM_MF) - 9'h1);
  localparam logic [7:0] RXF_ONES = 8'((9'h1 << NUM_RXF) - 9'h1);
  localparam logic [31:0] TX_VALID = {TXB_ONES, TXB_ONES};
  localparam logic [31:0] MF_VALID = {16'h0000, MF_ONES, MF_ONES};
  localparam logic [31:0] GFLAG_VALID = {8'h00, RXF_ONES, 16'h000F};

  // Byte-enable merge of a write into an old register value.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave with one wait state.

  cie_bus_state_t bus_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic take;
  logic wr;
  logic rd;
  logic glob;
  logic ch_hit;
  logic [2:0] chsel;
  logic [4:0] ofs;
  logic [31:0] bemask;
  logic [31:0] rmux;

  assign take = (avs_read || avs_write) && (bus_r == CIE_BUS_IDLE);
  assign wr = take && avs_write;
  assign rd = take && avs_read && !avs_write;
  assign glob = avs_address[7:5] == 3'h0;
  assign chsel = avs_address[7:5] - `CIE_CH_BASE_IDX;
  assign ch_hit = (avs_address[7:5] >= `CIE_CH_BASE_IDX) && (32'(chsel) < NUM_CH);
  // Byte address bits 1:0 are ignored, so every register answers on its whole word.
  assign ofs = {avs_address[4:2], 2'b00};
  assign bemask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // A request is taken in the idle state and answered at the next edge.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_r <= CIE_BUS_IDLE;
      wait_r <= 1'b1;
    end else begin
      bus_r <= take ? CIE_BUS_DONE : CIE_BUS_IDLE;
      wait_r <= !take;
    end
  end

  // Read data is zero except in the answering cycle, which keeps stale state off the bus.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= rd ? rmux : 32'h00000000;
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Global error and common receive FIFO sources.

  logic [3:0] gerr_en_r;
  logic [3:0] exp_dlc_r;
  logic [NUM_RXF-1:0] rxf_en_r;
  logic [3:0] gflag_r;
  logic [NUM_RXF-1:0] rxf_flag_r;
  logic [3:0] gev;
  logic [31:0] gclr;

  // Bit order of the global error field: short length, message lost, history lost, parity.
  assign gev[0] = gerr_ev.frame_valid && (gerr_ev.dlc < exp_dlc_r);
  assign gev[1] = gerr_ev.msg_lost;
  assign gev[2] = gerr_ev.hist_lost;
  assign gev[3] = gerr_ev.ram_parity;
  assign gclr = (wr && glob && ofs == `CIE_GFLAG_OFS) ? (avs_writedata & bemask) : 32'h0;

  // Global enable and configuration registers.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gerr_en_r <= 4'(`CIE_EN_RST);
      exp_dlc_r <= `CIE_EXP_DLC_RST;
      rxf_en_r <= NUM_RXF'(`CIE_EN_RST);
    end else if (wr && glob) begin
      case (ofs)
        `CIE_GERR_EN_OFS: gerr_en_r <= 4'(merge({28'h0, gerr_en_r}, avs_writedata, avs_byteenable));
        `CIE_EXP_DLC_OFS: exp_dlc_r <= 4'(merge({28'h0, exp_dlc_r}, avs_writedata, avs_byteenable));
        `CIE_RXF_EN_OFS: rxf_en_r <= NUM_RXF'(merge(32'(rxf_en_r), avs_writedata, avs_byteenable));
        default: ;
      endcase
    end
  end

  // Sticky flags: only enabled events land, and a new event beats a same-cycle clear.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gflag_r <= 4'h0;
      rxf_flag_r <= '0;
    end else begin
      gflag_r <= (gflag_r & ~gclr[3:0]) | (gev & gerr_en_r);
      rxf_flag_r <= (rxf_flag_r & ~gclr[`CIE_RXFFLG_LSB +: NUM_RXF]) | (rxf_ev & rxf_en_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-channel sources.

  logic [31:0] iew_r [NUM_CH];
  logic [31:0] txen_r [NUM_CH];
  logic [31:0] mfen_r [NUM_CH];
  logic [31:0] txflg_r [NUM_CH];
  logic [31:0] mfflg_r [NUM_CH];
  logic [31:0] miscflg_r [NUM_CH];
  logic [NUM_CH-1:0] warn_q_r;
  logic [NUM_CH-1:0] pas_q_r;
  logic [NUM_CH-1:0] boff_q_r;
  logic [31:0] txev [NUM_CH];
  logic [31:0] mfev [NUM_CH];
  logic [31:0] miscev [NUM_CH];
  logic [7:0] cev [NUM_CH];
  logic [31:0] chclr [NUM_CH];

  // Event vectors laid out exactly like the enable registers.
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      cev[c][0] = ch_ev[c].bit_err;
      cev[c][1] = ch_ev[c].warn_lvl && !warn_q_r[c];
      cev[c][2] = ch_ev[c].passive_lvl && !pas_q_r[c];
      cev[c][3] = ch_ev[c].bus_off_lvl && !boff_q_r[c];
      cev[c][4] = !ch_ev[c].bus_off_lvl && boff_q_r[c];
      cev[c][5] = ch_ev[c].overload;
      cev[c][6] = ch_ev[c].dom_lock;
      cev[c][7] = ch_ev[c].arb_lost;
      txev[c] = {ch_ev[c].tx_abort, ch_ev[c].tx_done} & TX_VALID;
      mfev[c] = {16'h0000, ch_ev[c].mf_tx, ch_ev[c].mf_rx} & MF_VALID;
      miscev[c] = {16'h0000, cev[c], 6'h00, ch_ev[c].hist, ch_ev[c].txq};
      chclr[c] = (wr && ch_hit && chsel == 3'(c)) ? (avs_writedata & bemask) : 32'h0;
    end
  end

  // Previous error levels, so only crossings count as events: each rising one, and the fall out of bus-off.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      warn_q_r <= '0;
      pas_q_r <= '0;
      boff_q_r <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        warn_q_r[c] <= ch_ev[c].warn_lvl;
        pas_q_r[c] <= ch_ev[c].passive_lvl;
        boff_q_r[c] <= ch_ev[c].bus_off_lvl;
      end
    end
  end

  // Channel enable registers and the whole-source disable command.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < NUM_CH; c++) begin
        iew_r[c] <= `CIE_EN_RST;
        txen_r[c] <= `CIE_EN_RST;
        mfen_r[c] <= `CIE_EN_RST;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (wr && ch_hit && chsel == 3'(c)) begin
          case (ofs)
            `CIE_IEW_OFS: iew_r[c] <= merge(iew_r[c], avs_writedata, avs_byteenable) & `CIE_IEW_VALID;
            `CIE_TXEN_OFS: txen_r[c] <= merge(txen_r[c], avs_writedata, avs_byteenable) & TX_VALID;
            `CIE_MFEN_OFS: mfen_r[c] <= merge(mfen_r[c], avs_writedata, avs_byteenable) & MF_VALID;
            `CIE_NOINT_OFS: begin
              case (cie_src_t'(avs_writedata[3:0]))
                CIE_SRC_TX: txen_r[c][15:0] <= 16'h0000;
                CIE_SRC_TXA: txen_r[c][31:16] <= 16'h0000;
                CIE_SRC_TXQ: iew_r[c][0] <= 1'b0;
                CIE_SRC_TXHL: iew_r[c][1] <= 1'b0;
                CIE_SRC_CERR: iew_r[c][15:8] <= 8'h00;
                CIE_SRC_RXCF: mfen_r[c][7:0] <= 8'h00;
                CIE_SRC_TXCF: mfen_r[c][15:8] <= 8'h00;
                default: ;
              endcase
            end
            default: ;
          endcase
        end
      end
    end
  end

  // Channel flags: latched only while enabled, cleared by writing ones, set beats clear.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < NUM_CH; c++) begin
        txflg_r[c] <= 32'h0;
        mfflg_r[c] <= 32'h0;
        miscflg_r[c] <= 32'h0;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        txflg_r[c] <= (txflg_r[c] & ~(ofs == `CIE_TXFLG_OFS ? chclr[c] : 32'h0)) |
                      (txev[c] & txen_r[c]);
        mfflg_r[c] <= (mfflg_r[c] & ~(ofs == `CIE_MFFLG_OFS ? chclr[c] : 32'h0)) |
                      (mfev[c] & mfen_r[c]);
        miscflg_r[c] <= (miscflg_r[c] & ~(ofs == `CIE_MISCFLG_OFS ? chclr[c] : 32'h0)) |
                        (miscev[c] & iew_r[c]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read multiplexer.

  // Unmapped addresses and the write-only command word read as zero.
  always_comb begin
    rmux = 32'h0;
    if (glob) begin
      case (ofs)
        `CIE_GERR_EN_OFS: rmux = {28'h0, gerr_en_r};
        `CIE_EXP_DLC_OFS: rmux = {28'h0, exp_dlc_r};
        `CIE_RXF_EN_OFS: rmux = 32'(rxf_en_r);
        `CIE_GFLAG_OFS: rmux = {8'h00, 8'(rxf_flag_r), 12'h000, gflag_r} & GFLAG_VALID;
        default: rmux = 32'h0;
      endcase
    end else if (ch_hit) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (chsel == 3'(c)) begin
          case (ofs)
            `CIE_IEW_OFS: rmux = iew_r[c];
            `CIE_TXEN_OFS: rmux = txen_r[c];
            `CIE_MFEN_OFS: rmux = mfen_r[c];
            `CIE_TXFLG_OFS: rmux = txflg_r[c];
            `CIE_MFFLG_OFS: rmux = mfflg_r[c];
            `CIE_MISCFLG_OFS: rmux = miscflg_r[c];
            default: rmux = 32'h0;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Request lines, one per group, registered so the outputs are glitch free.

  // A request stays up while any flag of its group is pending; the cost is one cycle.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gerr_irq <= 1'b0;
      rxf_irq <= '0;
      tx_irq <= '0;
      tx_abort_irq <= '0;
      tx_queue_irq <= '0;
      tx_history_irq <= '0;
      cerr_irq <= '0;
      multi_fifo_rx_irq <= '0;
      multi_fifo_tx_irq <= '0;
    end else begin
      gerr_irq <= |gflag_r;
      rxf_irq <= rxf_flag_r;
      for (int c = 0; c < NUM_CH; c++) begin
        tx_irq[c] <= |txflg_r[c][15:0];
        tx_abort_irq[c] <= |txflg_r[c][`CIE_ABORT_LSB +: 16];
        tx_queue_irq[c] <= miscflg_r[c][0];
        tx_history_irq[c] <= miscflg_r[c][1];
        cerr_irq[c] <= |miscflg_r[c][`CIE_CERR_LSB +: 8];
        multi_fifo_rx_irq[c] <= |mfflg_r[c][7:0];
        multi_fifo_tx_irq[c] <= |mfflg_r[c][`CIE_MFTX_LSB +: 8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions and covers.

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_short_dlc: assert property (gev[0] && gerr_en_r[0] |-> ##2 gerr_irq)
    else $error("short length event did not raise global error request");
  a_lost_latch: assert property (gerr_ev.msg_lost && gerr_en_r[1] |=> gflag_r[1])
    else $error("message lost event not latched");
  a_disabled_drop: assert property (gerr_ev.hist_lost && !gerr_en_r[2] && !gflag_r[2] |=> !gflag_r[2])
    else $error("disabled history lost event was latched");
  a_parity_req: assert property (gerr_ev.ram_parity && gerr_en_r[3] |-> ##2 gerr_irq)
    else $error("parity failure did not raise request");
  a_gerr_quiet: assert property (gerr_en_r == 4'h0 && gflag_r == 4'h0 |=> ##1 !gerr_irq)
    else $error("global error request with all enables clear");
  a_rxf_req: assert property (rxf_ev[NUM_RXF-1] && rxf_en_r[NUM_RXF-1] |-> ##2 rxf_irq[NUM_RXF-1])
    else $error("receive FIFO event did not raise request");
  a_tx_done: assert property (ch_ev[0].tx_done[NUM_TXBUF-1] && txen_r[0][NUM_TXBUF-1] |-> ##2 tx_irq[0])
    else $error("transmit done did not raise request");
  a_tx_abort: assert property (ch_ev[0].tx_abort[0] && txen_r[0][16] |-> ##2 tx_abort_irq[0])
    else $error("transmit abort did not raise request");
  // Error level checks watch the last channel, whose levels the engine model moves.
  a_warn_rise: assert property ($rose(ch_ev[NUM_CH-1].warn_lvl) && iew_r[NUM_CH-1][9]
                                |-> ##2 cerr_irq[NUM_CH-1])
    else $error("warning crossing did not raise channel error");
  a_busoff_entry: assert property ($rose(ch_ev[NUM_CH-1].bus_off_lvl) && iew_r[NUM_CH-1][11]
                                   |=> miscflg_r[NUM_CH-1][11])
    else $error("bus-off entry not latched");
  a_recovered: assert property ($fell(ch_ev[NUM_CH-1].bus_off_lvl) && iew_r[NUM_CH-1][12]
                                |=> miscflg_r[NUM_CH-1][12])
    else $error("bus-off recovery not latched");
  a_bit_err: assert property (ch_ev[NUM_CH-1].bit_err && iew_r[NUM_CH-1][8]
                              |-> ##2 cerr_irq[NUM_CH-1])
    else $error("bit error did not raise channel error");
  a_cerr_quiet: assert property (iew_r[0][15:8] == 8'h00 && miscflg_r[0][15:8] == 8'h00
                                 |=> ##1 !cerr_irq[0])
    else $error("channel error request with all enables clear");
  a_txq_req: assert property (ch_ev[0].txq && iew_r[0][0] |-> ##2 tx_queue_irq[0])
    else $error("transmit queue event did not raise request");
  a_hist_req: assert property (ch_ev[0].hist && iew_r[0][1] |-> ##2 tx_history_irq[0])
    else $error("history list event did not raise request");
  a_mfrx_req: assert property (ch_ev[0].mf_rx[0] && mfen_r[0][0] |-> ##2 multi_fifo_rx_irq[0])
    else $error("multi-purpose FIFO receive event did not raise request");
  a_mftx_req: assert property (ch_ev[0].mf_tx[NUM_MF-1] && mfen_r[0][`CIE_MFTX_LSB + NUM_MF - 1]
                               |-> ##2 multi_fifo_tx_irq[0])
    else $error("multi-purpose FIFO transmit event did not raise request");
  a_noint_cerr: assert property (wr && ch_hit && chsel == 3'h0 && ofs == `CIE_NOINT_OFS &&
                                 avs_writedata[3:0] == 4'h5 |=> iew_r[0][15:8] == 8'h00)
    else $error("whole-source disable left channel error enables set");
  a_bus_answer: assert property (take |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle after request");

  c_read: cover property (rd ##1 !avs_waitrequest);
  c_write: cover property (wr ##1 !avs_waitrequest);
  c_cerr: cover property (!cerr_irq[0] ##1 cerr_irq[0]);
  c_clear_race: cover property (|gclr[3:0] && |(gev & gerr_en_r & gclr[3:0]));
  c_noint: cover property (wr && ch_hit && ofs == `CIE_NOINT_OFS);

endmodule

//--- cie_pkg.sv
// Types shared by the CAN interrupt enable block.
`include "cie_regs.svh"
package cie_pkg;
  // Global error events from the protocol engine and message RAM.
  typedef struct packed {
    logic frame_valid;
    logic [3:0] dlc;
    logic msg_lost;
    logic hist_lost;
    logic ram_parity;
  } cie_gerr_ev_t;
  // Per-channel events; the three level fields are error states, not pulses.
  typedef struct packed {
    logic [`CIE_TXB_MAX-1:0] tx_done;
    logic [`CIE_TXB_MAX-1:0] tx_abort;
    logic txq;
    logic hist;
    logic [`CIE_MF_MAX-1:0] mf_rx;
    logic [`CIE_MF_MAX-1:0] mf_tx;
    logic bit_err;
    logic overload;
    logic dom_lock;
    logic arb_lost;
    logic warn_lvl;
    logic passive_lvl;
    logic bus_off_lvl;
  } cie_ch_ev_t;
  // Source codes for the disable_whole_source command.
  typedef enum logic [3:0] {
    CIE_SRC_TX = 4'h1, CIE_SRC_TXA = 4'h2, CIE_SRC_TXQ = 4'h3, CIE_SRC_TXHL = 4'h4,
    CIE_SRC_CERR = 4'h5, CIE_SRC_RXCF = 4'h6, CIE_SRC_TXCF = 4'h7
  } cie_src_t;
  typedef enum logic [1:0] {CIE_BUS_IDLE = 2'h0, CIE_BUS_DONE = 2'h1} cie_bus_state_t;
endpackage

//--- cie_regs.svh
// Register offsets, field positions and reset values of the CAN interrupt enable block.
// What this block does
// - Per-channel interrupt enable word, set bit enables.
// - Events of disabled sources are discarded, never latched.
// - Short received length raises a global error.
// - Message lost and history lost, separately enabled.
// - Message RAM parity failure raises a global error.
// - Global error enables independent; all clear disables.
// - Each common receive FIFO has its own enable.
// - Per transmit buffer transmit-complete enable, by index.
// - Per transmit buffer abort enable, separate from complete.
// - Single-bit transmit queue and history list enables.
// - Per multi-purpose FIFO receive enable.
// - Per multi-purpose FIFO transmit enable, separate.
// - Channel error enables independent; all clear disables.
// - Bit error raises channel error when enabled.
// - Rising into warning level raises channel error.
// - Rising into passive level raises channel error.
// - Entering bus-off raises channel error when enabled.
// - Completed bus-off recovery raises channel error.
// - Overload frame raises channel error when enabled.
// - Bus stuck dominant raises channel error.
// - Lost arbitration raises channel error when enabled.
// - One command disables every enable of a source.
`ifndef CIE_REGS_SVH
`define CIE_REGS_SVH
`define CIE_GERR_EN_OFS 5'h00
`define CIE_EXP_DLC_OFS 5'h04
`define CIE_RXF_EN_OFS 5'h08
`define CIE_GFLAG_OFS 5'h0C
`define CIE_CH_BASE_IDX 3'h2
`define CIE_IEW_OFS 5'h00
`define CIE_TXEN_OFS 5'h04
`define CIE_MFEN_OFS 5'h08
`define CIE_TXFLG_OFS 5'h0C
`define CIE_MFFLG_OFS 5'h10
`define CIE_MISCFLG_OFS 5'h14
`define CIE_NOINT_OFS 5'h18
`define CIE_CERR_LSB 8
`define CIE_ABORT_LSB 16
`define CIE_MFTX_LSB 8
`define CIE_RXFFLG_LSB 16
`define CIE_IEW_VALID 32'h0000FF03
`define CIE_EN_RST 32'h00000000
`define CIE_EXP_DLC_RST 4'h0
`define CIE_TXB_MAX 16
`define CIE_MF_MAX 8
`endif

//--- tb_top.sv
// Self-checking testbench of the CAN interrupt enable block.
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); fail_count++; end end
module tb_top;
  import cie_pkg::*;
  logic clock, rst, avs_read, avs_write, avs_waitrequest, gerr_irq;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd_v;
  logic [3:0] avs_byteenable;
  cie_gerr_ev_t gerr_ev;
  logic [7:0] rxf_ev, rxf_irq;
  cie_ch_ev_t ch_ev [2];
  logic [1:0] tx_irq, tx_abort_irq, tx_queue_irq, tx_history_irq, cerr_irq, multi_fifo_rx_irq, multi_fifo_tx_irq;
  logic [22:0] all_irq;
  int fail_count = 0;
  int n_tests = 0;
  // All request lines in one vector, so one compare sees stray requests too.
  assign all_irq = {gerr_irq, rxf_irq, tx_irq, tx_abort_irq, tx_queue_irq, tx_history_irq, cerr_irq,
                    multi_fifo_rx_irq, multi_fifo_tx_irq};
  cie_irq_enable cie_irq_enable_inst (.clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .gerr_ev(gerr_ev), .rxf_ev(rxf_ev), .ch_ev(ch_ev), .gerr_irq(gerr_irq), .rxf_irq(rxf_irq),
    .tx_irq(tx_irq), .tx_abort_irq(tx_abort_irq), .tx_queue_irq(tx_queue_irq),
    .tx_history_irq(tx_history_irq), .cerr_irq(cerr_irq), .multi_fifo_rx_irq(multi_fifo_rx_irq),
    .multi_fifo_tx_irq(multi_fifo_tx_irq));
  cie_evt_src cie_evt_src_inst (.clock(clock), .gerr_ev(gerr_ev), .rxf_ev(rxf_ev), .ch_ev(ch_ev));
  // Free-running 25 MHz clock.
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One Avalon access; the request is held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, avs_waitrequest, 1'b0);
      fail_count++;
    end
    rd_v = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    `CHK(rd_v, e)
  endtask
  // Clearing a flag must drop every request line again.
  task automatic clr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    @(posedge clock);
    #1 `CHK(all_irq, 23'h0)
  endtask
  // A request appears exactly two cycles after the event cycle, not sooner.
  task automatic evc(input int p);
    #1 `CHK(all_irq, 23'h0)
    @(posedge clock);
    #1 `CHK(all_irq, (p < 0) ? 23'h0 : 23'h1 << p)
  endtask
  function automatic logic [7:0] cb(input int c, input logic [7:0] o);
    return 8'h40 + 8'(c * 32) + o;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdc(8'h00, 32'h0);
    rdc(8'h08, 32'h0);
    rdc(cb(1, 8'h00), 32'h0);
    bus(1'b1, cb(1, 8'h00), 32'hFFFFFFFF);
    rdc(cb(1, 8'h00), 32'h0000FF03);
    rdc(8'h30, 32'h0);
    rdc(cb(1, 8'h18), 32'h0);
    bus(1'b1, cb(1, 8'h00), 32'h0);
  endtask
  task automatic t_gerr();
    bus(1'b1, 8'h04, 32'h5);
    bus(1'b1, 8'h00, 32'hF);
    cie_evt_src_inst.gerr_pulse(8'hA8);
    evc(-1);
    cie_evt_src_inst.gerr_pulse(8'hA0);
    evc(22);
    rdc(8'h0C, 32'h1);
    clr(8'h0C, 32'h1);
    for (int k = 1; k <= 3; k++) begin
      cie_evt_src_inst.gerr_pulse(8'h1 << (3 - k));
      evc(22);
      rdc(8'h0C, 32'h1 << k);
      clr(8'h0C, 32'h1 << k);
    end
    // Only the message lost source stays enabled; history lost must be dropped.
    bus(1'b1, 8'h00, 32'h2);
    cie_evt_src_inst.gerr_pulse(8'h06);
    evc(22);
    rdc(8'h0C, 32'h2);
    clr(8'h0C, 32'h2);
    bus(1'b1, 8'h00, 32'h0);
    cie_evt_src_inst.gerr_pulse(8'hA7);
    evc(-1);
  endtask
  task automatic t_rxf();
    bus(1'b1, 8'h08, 32'h80);
    cie_evt_src_inst.rxf_pulse(8'hFF);
    evc(21);
    rdc(8'h0C, 32'h00800000);
    clr(8'h0C, 32'h00800000);
  endtask
  task automatic t_cerr();
    cie_ch_ev_t v;
    v = '0;
    v.bit_err = 1'b1;
    cie_evt_src_inst.ch_pulse(1, v);
    bus(1'b1, cb(1, 8'h00), 32'h100);
    evc(-1);
    for (int b = 8; b <= 15; b++) begin
      bus(1'b1, cb(1, 8'h00), 32'h1 << b);
      v = '0;
      case (b)
        8: v.bit_err = 1'b1;
        9: v.warn_lvl = 1'b1;
        10: v.passive_lvl = 1'b1;
        11: v.bus_off_lvl = 1'b1;
        13: v.overload = 1'b1;
        14: v.dom_lock = 1'b1;
        15: v.arb_lost = 1'b1;
        default: begin
          v.bus_off_lvl = 1'b1;
          cie_evt_src_inst.ch_pulse(1, v);
          evc(-1);
          v = '0;
        end
      endcase
      cie_evt_src_inst.ch_pulse(1, v);
      evc(5);
      rdc(cb(1, 8'h14), 32'h1 << b);
      clr(cb(1, 8'h14), 32'h1 << b);
      // Falling levels are not events of the enabled source; the bus-off fall is a recovery event.
      cie_evt_src_inst.ch_pulse(1, '0);
      evc(-1);
    end
  endtask
  task automatic t_tx();
    cie_ch_ev_t v;
    bus(1'b1, cb(0, 8'h04), 32'h00018000);
    bus(1'b1, cb(0, 8'h00), 32'h3);
    bus(1'b1, cb(0, 8'h08), 32'h0401);
    v = '0;
    v.tx_done = 16'h8001;
    v.tx_abort = 16'h8001;
    v.mf_rx = 8'h04;
    v.mf_tx = 8'h01;
    cie_evt_src_inst.ch_pulse(0, v);
    #1 `CHK(all_irq, 23'h0)
    @(posedge clock);
    #1 `CHK(all_irq, 23'h1400)
    rdc(cb(0, 8'h0C), 32'h00018000);
    clr(cb(0, 8'h0C), 32'h00018000);
    v = '0;
    v.txq = 1'b1;
    cie_evt_src_inst.ch_pulse(0, v);
    evc(8);
    v = '0;
    v.hist = 1'b1;
    cie_evt_src_inst.ch_pulse(0, v);
    #1 `CHK(all_irq, 23'h100)
    @(posedge clock);
    #1 `CHK(all_irq, 23'h140)
    rdc(cb(0, 8'h14), 32'h3);
    clr(cb(0, 8'h14), 32'h3);
    v = '0;
    v.mf_rx = 8'h01;
    v.mf_tx = 8'h04;
    cie_evt_src_inst.ch_pulse(0, v);
    #1 `CHK(all_irq, 23'h0)
    @(posedge clock);
    #1 `CHK(all_irq, 23'h5)
    rdc(cb(0, 8'h10), 32'h0401);
    clr(cb(0, 8'h10), 32'h0401);
  endtask
  // Each source code must clear its own enables and leave the rest alone.
  task automatic t_noint();
    logic [7:0] ofs [7] = '{8'h04, 8'h04, 8'h00, 8'h00, 8'h00, 8'h08, 8'h08};
    logic [31:0] exp [7] = '{32'hFFFF0000, 32'h0, 32'hFF02, 32'hFF00, 32'h0, 32'h0700, 32'h0};
    bus(1'b1, cb(0, 8'h00), 32'hFF03);
    bus(1'b1, cb(0, 8'h04), 32'hFFFFFFFF);
    bus(1'b1, cb(0, 8'h08), 32'h0707);
    bus(1'b1, cb(0, 8'h18), 32'h0);
    rdc(cb(0, 8'h00), 32'hFF03);
    for (int k = 1; k <= 7; k++) begin
      bus(1'b1, cb(0, 8'h18), 32'(k));
      rdc(cb(0, ofs[k - 1]), exp[k - 1]);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Main sequence: reset for six cycles, then every scenario in turn.
  initial begin
    rst = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hF;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_gerr();
    t_rxf();
    t_cerr();
    t_tx();
    t_noint();
    conclude();
  end
  // The scenarios need well under 2000 cycles; a hang ends the run here.
  initial begin
    repeat (20000) @(posedge clock);
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    fail_count++;
    conclude();
  end
endmodule
